// *** logic/dcc_channel.sv ***
// one comparator channel: gating, polarity, timer sync capture, edge detection
`timescale 1ns/100ps
module dcc_channel
(
  input  wire logic       i_clk,          // instruction clock
  input  wire logic       i_reset,        // synchronous reset
  input  wire logic       i_on,           // comparator_on
  input  wire logic       i_invert,       // invert_output
  input  wire logic       i_sync_en,      // timer_sync_enable
  input  wire logic       i_rise_en,      // rise_detect_enable
  input  wire logic       i_fall_en,      // fall_detect_enable
  input  wire logic       i_raw,          // analog decision
  input  wire logic       i_tmr_fall,     // falling edge of (prescaled) timer_one clock
  output logic            o_result,       // registered result
  output logic            o_async_result, // unlatched result for pin
  output logic            o_edge          // one-cycle edge event
);
  logic gated;
  logic pol;
  logic sync_q;
  logic sample;
  logic result_q;
  logic prev_q;

  assign gated = i_on & i_raw;                   // RL24 RL1
  assign pol   = gated ^ i_invert;               // RL6 RL7
  assign o_async_result = pol;                   // RL5

  // capture on timer fall so timer rising increment never sees a moving value
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      sync_q <= 1'b0;
    else if (i_tmr_fall)
      sync_q <= pol;                             // RL11 RL12 RL13
  end

  assign sample = i_sync_en ? sync_q : pol;      // RL23

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      result_q <= 1'b0;
      prev_q   <= 1'b0;
    end
    else
    begin
      result_q <= sample;                        // RL5
      prev_q   <= result_q;
    end
  end

  assign o_result = result_q;
  // polarity or enable toggles also land here even while off
  assign o_edge = (i_rise_en & result_q & ~prev_q)
                | (i_fall_en & ~result_q & prev_q);  // RL15 RL21 RL23
endmodule

// *** logic/dcc_pkg.sv ***
// package: register map, field positions and reset values of the dual comparator control
package dcc_pkg;
  localparam int          NUM_CMP         = 2;
  // byte offsets of the registers
  localparam logic [11:0] OFF_CTRL_A1     = 12'h000;
  localparam logic [11:0] OFF_CTRL_B1     = 12'h004;
  localparam logic [11:0] OFF_CTRL_A2     = 12'h008;
  localparam logic [11:0] OFF_CTRL_B2     = 12'h00c;
  localparam logic [11:0] OFF_MIRROR      = 12'h010;
  localparam logic [11:0] OFF_FLAGS       = 12'h014;
  localparam logic [11:0] OFF_IRQ_EN      = 12'h018;
  localparam logic [11:0] OFF_IRQ_CTRL    = 12'h01c;
  // comparator_control_a fields
  localparam int          A_ON            = 7;
  localparam int          A_RESULT        = 6;
  localparam int          A_PIN_DRIVE     = 5;
  localparam int          A_INVERT        = 4;
  localparam int          A_SPEED         = 2;
  localparam int          A_HYST          = 1;
  localparam int          A_SYNC          = 0;
  localparam logic [7:0]  A_WRITE_MASK    = 8'hb7;
  localparam logic [7:0]  A_RESET         = 8'h04;
  // comparator_control_b fields
  localparam int          B_RISE          = 7;
  localparam int          B_FALL          = 6;
  localparam int          B_PSEL_LO       = 4;
  localparam int          B_NSEL_LO       = 0;
  localparam logic [7:0]  B_WRITE_MASK    = 8'hf7;
  localparam logic [7:0]  B_RESET         = 8'h00;
  // irq_control_register fields
  localparam int          IRQ_GLOBAL      = 7;
  localparam int          IRQ_PERIPH      = 6;
  // positive input sources
  localparam logic [1:0]  PSEL_PIN        = 2'h0;
  localparam logic [1:0]  PSEL_DAC        = 2'h1;
  localparam logic [1:0]  PSEL_FIXED_REF  = 2'h2;
  localparam logic [1:0]  PSEL_GROUND     = 2'h3;
endpackage

// *** logic/dcc_top.sv ***
// dual comparator control: apb registers, two channels, pin override, timer gate and interrupt
//
// Operation
// RL1: comparator works only while comparator_on set; off means lowest current.
// RL2: result readable in control register and in shared mirror register.
// RL3: pin driven only with pin_drive_enable, direction clear, comparator_on set.
// RL4: pin_drive_enable overrides port latch; comparator_on does not affect override.
// RL5: internal result registered each cycle; pin output unlatched.
// RL6: raw decision high when plus exceeds minus input.
// RL7: invert_output complements the reported result.
// RL8: normal_speed_select resets to 1; 0 selects low power.
// RL9: hysteresis_enable adds hysteresis; clear means none.
// RL10: each result is a selectable timer_one gate source.
// RL11: with sync enabled, result captured at timer_one clock falling edge.
// RL12: with prescaler, capture uses the prescaled clock.
// RL13: timer counts on rising edge, capture on falling, never racing.
// RL14: software should enable sync when comparator gates timer_one.
// RL15: rise and fall detectors set event flag when enabled.
// RL16: interrupt forwarded only if flag, event, peripheral and global enables set.
// RL17: event flag stays until software clears; edge during clear wins.
// RL18: two-bit positive select: pin, dac, fixed_reference, ground.
// RL19: three-bit negative select routes an input source to inverting input.
// RL20: disabled comparator disconnects all its inputs.
// RL21: toggling polarity or enable while off can still raise events.
// RL22: software sets analog_select and direction bit before analog use.
// RL23: edge detectors watch polarised, synchronised result versus previous cycle.
// RL24: disabled comparator's raw decision forced low.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
module dcc_top
(
  input  wire logic        i_clk,            // 200 MHz instruction clock
  input  wire logic        i_reset,          // synchronous, active high
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb direction
  input  wire logic [11:0] paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic             pready,           // apb ready
  output logic [31:0]      prdata,           // apb read data
  output logic             pslverr,          // apb error
  input  wire logic [1:0]  i_raw_decision,   // analog core decisions
  input  wire logic [1:0]  i_pin_direction,  // pin_direction_bit of each output pin
  input  wire logic [1:0]  i_port_latch,     // port data latch of each output pin
  input  wire logic        i_tmr_clk,        // timer_one clock, prescaled when in use
  output logic [1:0]       o_pin_value,      // pin level after override
  output logic [1:0]       o_pin_oe,         // pin driver enable from comparator
  output logic [1:0]       o_pin_override,   // pin_drive_enable per pin
  output logic [1:0]       o_analog_power,   // comparator powered
  output logic [1:0]       o_inputs_connect, // input switches closed
  output logic [1:0]       o_normal_speed,   // normal_speed_select
  output logic [1:0]       o_hysteresis,     // hysteresis_enable
  output logic [3:0]       o_positive_sel,   // positive_input_select, two per comparator
  output logic [5:0]       o_negative_sel,   // negative_input_select, three per comparator
  output logic [1:0]       o_timer_gate,     // results as timer_one gate sources
  output logic             o_irq             // interrupt request level
);
  //////////////////////////////////////////////////////////////////////////////
  // register storage; bit 3 of both control registers is not implemented
  logic [7:0]  ctrl_a_q [2];
  logic [7:0]  ctrl_b_q [2];
  logic [1:0]  flag_q;
  logic [1:0]  event_en_q;
  logic [1:0]  irq_ctrl_q;
  logic [31:0] prdata_q;
  // timer_one clock edge detection
  logic        tmr_q;
  logic        tmr_prev_q;
  logic        tmr_fall;
  // control fields, one bit per comparator
  logic [1:0]  on_bit;
  logic [1:0]  drive_bit;
  logic [1:0]  invert_bit;
  logic [1:0]  speed_bit;
  logic [1:0]  hyst_bit;
  logic [1:0]  sync_bit;
  logic [1:0]  rise_bit;
  logic [1:0]  fall_bit;
  // channel outputs
  logic [1:0]  result;
  logic [1:0]  async_result;
  logic [1:0]  edge_ev;
  // interrupt terms
  logic [1:0]  irq_src;
  logic        global_en;
  logic        periph_en;
  // bus decode
  logic        setup_phase;
  logic        access_phase;
  logic        wr_en;
  logic        rd_en;
  logic        sel_ctrl_a1;
  logic        sel_ctrl_b1;
  logic        sel_ctrl_a2;
  logic        sel_ctrl_b2;
  logic        sel_mirror;
  logic        sel_flags;
  logic        sel_irq_en;
  logic        sel_irq_ctrl;
  logic        addr_ok;
  logic [1:0]  wr_ctrl_a;
  logic [1:0]  wr_ctrl_b;
  logic        wr_flags;
  logic        wr_irq_en;
  logic        wr_irq_ctrl;
  logic [7:0]  wdata_a;
  logic [7:0]  wdata_b;
  logic [1:0]  clr_flags;
  // read words, unimplemented bits zero
  logic [7:0]  rd_ctrl_a [2];
  logic [7:0]  rd_ctrl_b [2];
  logic [7:0]  rd_mirror;
  logic [7:0]  rd_flags;
  logic [7:0]  rd_irq_en;
  logic [7:0]  rd_irq_ctrl;
  logic [31:0] rd_word;

  //////////////////////////////////////////////////////////////////////////////
  // map, one byte in bits 7:0 of each aligned word:
  //   0x00/0x08 control a: 7 on, 6 result, 5 pin drive, 4 invert, 2 speed, 1 hyst, 0 sync
  //   0x04/0x0c control b: 7 rise, 6 fall, 5:4 positive select, 2:0 negative select
  //   0x10 result mirror, read only
  //   0x14 event flags, write one to clear
  //   0x18 event enables
  //   0x1c interrupt control: 7 global, 6 peripheral
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en        = access_phase & pwrite;
  assign rd_en        = setup_phase & ~pwrite;

  assign sel_ctrl_a1  = (paddr == dcc_pkg::OFF_CTRL_A1);
  assign sel_ctrl_b1  = (paddr == dcc_pkg::OFF_CTRL_B1);
  assign sel_ctrl_a2  = (paddr == dcc_pkg::OFF_CTRL_A2);
  assign sel_ctrl_b2  = (paddr == dcc_pkg::OFF_CTRL_B2);
  assign sel_mirror   = (paddr == dcc_pkg::OFF_MIRROR);
  assign sel_flags    = (paddr == dcc_pkg::OFF_FLAGS);
  assign sel_irq_en   = (paddr == dcc_pkg::OFF_IRQ_EN);
  assign sel_irq_ctrl = (paddr == dcc_pkg::OFF_IRQ_CTRL);
  assign addr_ok      = sel_ctrl_a1
                      | sel_ctrl_b1
                      | sel_ctrl_a2
                      | sel_ctrl_b2
                      | sel_mirror
                      | sel_flags
                      | sel_irq_en
                      | sel_irq_ctrl;

  assign wr_ctrl_a    = {wr_en & sel_ctrl_a2, wr_en & sel_ctrl_a1};
  assign wr_ctrl_b    = {wr_en & sel_ctrl_b2, wr_en & sel_ctrl_b1};
  assign wr_flags     = wr_en & sel_flags;
  assign wr_irq_en    = wr_en & sel_irq_en;
  assign wr_irq_ctrl  = wr_en & sel_irq_ctrl;
  assign wdata_a      = pwdata[7:0] & dcc_pkg::A_WRITE_MASK;
  assign wdata_b      = pwdata[7:0] & dcc_pkg::B_WRITE_MASK;

  // zero-wait slave; read data fetched in setup so it can leave a flop
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~addr_ok;

  //////////////////////////////////////////////////////////////////////////////
  // timer_one clock is synchronous to i_clk; detect its falling edge
  // two flops only shape the edge; the capture lags the pin by two cycles,
  // which the counter never sees since it moves on the other edge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tmr_q      <= 1'b0;
      tmr_prev_q <= 1'b0;
    end
    else
    begin
      tmr_q      <= i_tmr_clk;
      tmr_prev_q <= tmr_q;
    end
  end
  assign tmr_fall = tmr_prev_q & ~tmr_q;  // RL12 RL13

  //////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < dcc_pkg::NUM_CMP; g++)
    begin : gen_cmp
      always_ff @(posedge i_clk)
      begin
        if (i_reset)
        begin
          ctrl_a_q[g] <= dcc_pkg::A_RESET;  // RL8
        end
        else if (wr_ctrl_a[g])
        begin
          ctrl_a_q[g] <= wdata_a;
        end
      end

      always_ff @(posedge i_clk)
      begin
        if (i_reset)
        begin
          ctrl_b_q[g] <= dcc_pkg::B_RESET;
        end
        else if (wr_ctrl_b[g])
        begin
          ctrl_b_q[g] <= wdata_b;
        end
      end

      // fields of control register a
      assign on_bit[g]     = ctrl_a_q[g][dcc_pkg::A_ON];
      assign drive_bit[g]  = ctrl_a_q[g][dcc_pkg::A_PIN_DRIVE];
      assign invert_bit[g] = ctrl_a_q[g][dcc_pkg::A_INVERT];
      assign speed_bit[g]  = ctrl_a_q[g][dcc_pkg::A_SPEED];
      assign hyst_bit[g]   = ctrl_a_q[g][dcc_pkg::A_HYST];
      assign sync_bit[g]   = ctrl_a_q[g][dcc_pkg::A_SYNC];
      // fields of control register b
      assign rise_bit[g]   = ctrl_b_q[g][dcc_pkg::B_RISE];
      assign fall_bit[g]   = ctrl_b_q[g][dcc_pkg::B_FALL];

      dcc_channel u_channel
      (
        .i_clk          (i_clk),
        .i_reset        (i_reset),
        .i_on           (on_bit[g]),
        .i_invert       (invert_bit[g]),
        .i_sync_en      (sync_bit[g]),
        .i_rise_en      (rise_bit[g]),
        .i_fall_en      (fall_bit[g]),
        .i_raw          (i_raw_decision[g]),
        .i_tmr_fall     (tmr_fall),
        .o_result       (result[g]),
        .o_async_result (async_result[g]),
        .o_edge         (edge_ev[g])
      );

      assign o_analog_power[g]   = on_bit[g];     // RL1
      assign o_inputs_connect[g] = on_bit[g];     // RL20
      assign o_normal_speed[g]   = speed_bit[g];  // RL8
      assign o_hysteresis[g]     = hyst_bit[g];   // RL9
      assign o_positive_sel[2*g+1:2*g] = ctrl_b_q[g][dcc_pkg::B_PSEL_LO +: 2];      // RL18
      assign o_negative_sel[3*g+2:3*g] = ctrl_b_q[g][dcc_pkg::B_NSEL_LO +: 3];      // RL19
      assign o_timer_gate[g]     = result[g];                                       // RL10

      // override ignores comparator_on; the driver needs all three
      assign o_pin_override[g] = drive_bit[g];  // RL4
      assign o_pin_value[g]    = drive_bit[g] ? async_result[g] : i_port_latch[g];  // RL4 RL5
      assign o_pin_oe[g]       = drive_bit[g] & ~i_pin_direction[g] & on_bit[g];   // RL3

      // read words of the two control registers
      assign rd_ctrl_a[g] = {on_bit[g], result[g], drive_bit[g], invert_bit[g], 1'b0,
                             speed_bit[g], hyst_bit[g], sync_bit[g]};  // RL2
      assign rd_ctrl_b[g] = ctrl_b_q[g];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // write one to clear; a simultaneous edge keeps the flag set
  assign clr_flags = wr_flags ? pwdata[1:0] : 2'h0;

  // flags
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      flag_q <= 2'h0;
    end
    else
    begin
      flag_q <= (flag_q & ~clr_flags) | edge_ev;  // RL15 RL17
    end
  end

  // enables are written whole
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      event_en_q <= 2'h0;
    end
    else if (wr_irq_en)
    begin
      event_en_q <= pwdata[1:0];
    end
  end

  // only bits 7 and 6 are kept
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      irq_ctrl_q <= 2'h0;
    end
    else if (wr_irq_ctrl)
    begin
      irq_ctrl_q <= {pwdata[dcc_pkg::IRQ_GLOBAL], pwdata[dcc_pkg::IRQ_PERIPH]};
    end
  end

  // request only when a flag, its enable and both upper enables agree
  assign irq_src   = flag_q & event_en_q;
  assign global_en = irq_ctrl_q[1];
  assign periph_en = irq_ctrl_q[0];
  assign o_irq     = (|irq_src) & global_en & periph_en;  // RL16

  //////////////////////////////////////////////////////////////////////////////
  // read words of the shared registers
  assign rd_mirror   = {6'h00, result};  // RL2
  assign rd_flags    = {6'h00, flag_q};
  assign rd_irq_en   = {6'h00, event_en_q};
  assign rd_irq_ctrl = {irq_ctrl_q, 6'h00};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (paddr)
      dcc_pkg::OFF_CTRL_A1:  rd_word[7:0] = rd_ctrl_a[0];  // RL2
      dcc_pkg::OFF_CTRL_A2:  rd_word[7:0] = rd_ctrl_a[1];  // RL2
      dcc_pkg::OFF_CTRL_B1:  rd_word[7:0] = rd_ctrl_b[0];
      dcc_pkg::OFF_CTRL_B2:  rd_word[7:0] = rd_ctrl_b[1];
      dcc_pkg::OFF_MIRROR:   rd_word[7:0] = rd_mirror;     // RL2
      dcc_pkg::OFF_FLAGS:    rd_word[7:0] = rd_flags;
      dcc_pkg::OFF_IRQ_EN:   rd_word[7:0] = rd_irq_en;
      dcc_pkg::OFF_IRQ_CTRL: rd_word[7:0] = rd_irq_ctrl;
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // fetched in setup, zero again once the access phase has passed
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      prdata_q <= rd_word;
    end
    else
    begin
      prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_q;
endmodule

// *** verification/dcc_analog_model.sv ***
// analog core and timer clock stand-in for the dual comparator control
`timescale 1ns/100ps
module dcc_analog_model
(
  input  wire logic        i_clk,     // clock
  input  wire logic [15:0] i_plus,    // plus levels, [7:0] comp1
  input  wire logic [15:0] i_minus,   // minus levels
  input  wire logic        i_tmr_run, // timer clock running
  output logic [1:0]       o_raw,     // decisions
  output logic             o_tmr_clk  // prescaled timer clock
);
  logic [1:0] div_q = 2'h0;

  // divide by four as a prescaler; stands high while stopped
  always_ff @(posedge i_clk)
    div_q <= i_tmr_run ? div_q + 2'h1 : 2'h0;
  assign o_tmr_clk = ~div_q[1];
  assign o_raw[0]  = i_plus[7:0] > i_minus[7:0];
  assign o_raw[1]  = i_plus[15:8] > i_minus[15:8];
endmodule

// *** verification/dcc_top_assertions.sv ***
// checker: port properties of the dual comparator control
`timescale 1ns/100ps
module dcc_top_checker
(
  input wire logic       i_clk,            // clock
  input wire logic       i_reset,          // reset
  input wire logic       psel,             // select
  input wire logic       penable,          // access
  input wire logic       pwrite,           // write
  input wire logic [1:0] i_raw_decision,   // decisions
  input wire logic [1:0] i_pin_direction,  // direction
  input wire logic [1:0] i_port_latch,     // latch
  input wire logic [1:0] o_pin_value,      // pin level
  input wire logic [1:0] o_pin_oe,         // pin enable
  input wire logic [1:0] o_pin_override,   // override
  input wire logic [1:0] o_analog_power,   // power
  input wire logic [1:0] o_inputs_connect, // inputs
  input wire logic [1:0] o_normal_speed,   // speed
  input wire logic [1:0] o_timer_gate,     // results
  input wire logic       o_irq             // interrupt
);
  logic wr;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  assign wr = psel & penable & pwrite;
  //////////////////////////////////////////////////////////////
  pin_enable_a:
    assert property (o_pin_oe == (o_pin_override & ~i_pin_direction & o_analog_power)) else $error("pin enable");
  port_latch_a:
    assert property (((o_pin_value ^ i_port_latch) & ~o_pin_override) == 2'h0) else $error("port latch");
  inputs_off_a:
    assert property (o_inputs_connect == o_analog_power) else $error("input switches");
  speed_default_a:
    assert property ($past(i_reset) |-> o_normal_speed == 2'h3) else $error("speed default");
  polarity_track_a:
    assert property (!$past(wr) && o_pin_override[0] && o_analog_power[0]
      |-> $stable(o_pin_value[0] ^ i_raw_decision[0])) else $error("polarity");
  forced_low_a:
    assert property (!$past(wr) && o_pin_override[0] && !o_analog_power[0] |-> $stable(o_pin_value[0]))
      else $error("off result moved");
  flag_clear_a:
    assert property ($fell(o_irq) |-> $past(wr)) else $error("flag dropped");
  event_cause_a:
    assert property ($rose(o_irq) |-> $past(wr) || ($past(o_timer_gate) != $past(o_timer_gate, 2)))
      else $error("event without edge");
endmodule

bind dcc_top dcc_top_checker u_dcc_top_checker (.i_clk, .i_reset, .psel, .penable, .pwrite, .i_raw_decision,
  .i_pin_direction, .i_port_latch, .o_pin_value, .o_pin_oe, .o_pin_override, .o_analog_power, .o_inputs_connect,
  .o_normal_speed, .o_timer_gate, .o_irq);

// *** verification/test_dual_comparator_control.sv ***
// testbench: random and corner scenarios for the dual comparator control
`timescale 1ns/100ps
module test_dual_comparator_control;
  logic        i_clk = 1'b0, i_reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tmr_run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] plus = 16'h0, minus = 16'h0;
  logic [1:0]  dir = 2'h3, latch = 2'h0, raw, pin_val, pin_oe, pin_ovr, pwr, conn, spd, hys, gate;
  logic [3:0]  psl;
  logic [5:0]  nsl;
  logic [7:0]  v, p, m;
  logic        pready, pslverr, tmr, irq, e;
  int          fail_count = 0, check_count = 0;

  always #2.5 i_clk = ~i_clk;
  dcc_analog_model u_dcc_analog_model (.i_clk(i_clk), .i_plus(plus), .i_minus(minus), .i_tmr_run(tmr_run),
    .o_raw(raw), .o_tmr_clk(tmr));
  dcc_top u_dcc_top (.i_clk, .i_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .i_raw_decision(raw), .i_pin_direction(dir), .i_port_latch(latch), .i_tmr_clk(tmr), .o_pin_value(pin_val),
    .o_pin_oe(pin_oe), .o_pin_override(pin_ovr), .o_analog_power(pwr), .o_inputs_connect(conn),
    .o_normal_speed(spd), .o_hysteresis(hys), .o_positive_sel(psl), .o_negative_sel(nsl), .o_timer_gate(gate),
    .o_irq(irq));
  //////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      fail_count++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // let the edge's register updates land before looking
  task automatic settle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  function automatic logic pol(input logic [7:0] a, input logic [7:0] b, input logic on, input logic inv);
    return ((a > b) & on) ^ inv;
  endfunction
  task automatic conclude;
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h3c65da4d));
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    settle(1);
    check(spd, 2'h3);
    apb(1'b0, dcc_pkg::OFF_CTRL_A1, 8'h00);
    check(rd, 32'h04);
    apb(1'b0, 12'h020, 8'h00);
    check({rd[7:0], e}, 9'h001);
    apb(1'b1, dcc_pkg::OFF_CTRL_A1, 8'h02);
    settle(0);
    check({hys, spd}, 4'h6);
    for (int i = 0; i < 4; i++)
    begin
      v = {2'h0, 2'(i), 1'b0, 3'($urandom)};
      apb(1'b1, dcc_pkg::OFF_CTRL_B1, v);
      settle(0);
      check({psl[1:0], nsl[2:0]}, {v[5:4], v[2:0]});
    end
    for (int i = 0; i < 16; i++)
    begin
      v = 8'($urandom) & 8'hb0;
      p = 8'($urandom);
      m = 8'($urandom);
      @(posedge i_clk);
      plus[7:0] <= p;
      minus[7:0] <= m;
      dir <= 2'($urandom);
      latch <= 2'($urandom);
      apb(1'b1, dcc_pkg::OFF_CTRL_A1, v);
      settle(2);
      check(pin_oe[0], v[7] & v[5] & ~dir[0]);
      check(pin_val[0], v[5] ? pol(p, m, v[7], v[4]) : latch[0]);
      check({conn[0], pwr[0]}, {2{v[7]}});
      check(gate[0], pol(p, m, v[7], v[4]));
      apb(1'b0, dcc_pkg::OFF_CTRL_A1, 8'h00);
      check(rd[6], pol(p, m, v[7], v[4]));
      apb(1'b0, dcc_pkg::OFF_MIRROR, 8'h00);
      check(rd[0], pol(p, m, v[7], v[4]));
    end
    @(posedge i_clk);
    plus[7:0] <= 8'h00;
    minus[7:0] <= 8'h80;
    apb(1'b1, dcc_pkg::OFF_CTRL_A1, 8'h80);
    apb(1'b1, dcc_pkg::OFF_CTRL_B1, 8'h80);
    apb(1'b1, dcc_pkg::OFF_IRQ_EN, 8'h01);
    apb(1'b1, dcc_pkg::OFF_IRQ_CTRL, 8'hc0);
    apb(1'b1, dcc_pkg::OFF_FLAGS, 8'h03);
    settle(2);
    check(irq, 1'b0);
    @(posedge i_clk);
    plus[7:0] <= 8'hff;
    settle(4);
    check(irq, 1'b1);
    apb(1'b1, dcc_pkg::OFF_IRQ_CTRL, 8'h40);
    settle(0);
    check(irq, 1'b0);
    apb(1'b1, dcc_pkg::OFF_IRQ_CTRL, 8'hc0);
    apb(1'b0, dcc_pkg::OFF_FLAGS, 8'h00);
    check(rd[0], 1'b1);
    apb(1'b1, dcc_pkg::OFF_FLAGS, 8'h01);
    @(posedge i_clk);
    plus[7:0] <= 8'h00;
    settle(4);
    check(irq, 1'b0);
    apb(1'b1, dcc_pkg::OFF_CTRL_A1, 8'h10);
    settle(4);
    check(irq, 1'b1);
    apb(1'b1, dcc_pkg::OFF_CTRL_A1, 8'h80);
    // rising edge lands on the very edge of the clearing write
    fork
      apb(1'b1, dcc_pkg::OFF_FLAGS, 8'h01);
      begin
        @(posedge i_clk);
        plus[7:0] <= 8'hff;
      end
    join
    apb(1'b0, dcc_pkg::OFF_FLAGS, 8'h00);
    check(rd[0], 1'b1);
    apb(1'b1, dcc_pkg::OFF_CTRL_A2, 8'h81);
    @(posedge i_clk);
    plus[15:8] <= 8'hff;
    settle(8);
    check(gate[1], 1'b0);
    @(posedge i_clk);
    tmr_run <= 1'b1;
    settle(12);
    check(gate[1], 1'b1);
    conclude();
  end
  initial
  begin
    #50000;
    fail_count++;
    conclude();
  end
endmodule
